// File: ir_carrier_modulation_timer.sv
// Purpose: infrared carrier generator, interval modulator and receive capture timer
// Assumes: receive pin is asynchronous; registers on a plain strobed port
// Notes: read data appear one cycle after the read strobe
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
// Contract
// RL1: infrared clock is system clock divided by two to the divider field.
// RL2: carrier high for high byte plus one, low for low byte plus one.
// RL3: carrier, polarity and data bit are latched at each interval start.
// RL4: enabled transmit pin idles at polarity level; polarity one inverts carrier.
// RL5: transmit counter clocked by carrier, or infrared clock when select is one.
// RL6: data bit one sends carrier for the interval, zero sends idle level.
// RL7: transmission starts when enable and transmit mode become both set.
// RL8: at zero, next counting clock reloads, resamples, updates pin, sets flag.
// RL9: leaving transmit mode or clearing enable stops transmission.
// RL10: each interval lasts modulation time plus one counting clocks.
// RL11: envelope modes drive data bit, inverted by polarity, onto envelope pin.
// RL12: envelope 01b sends modulated carrier, 10b continuous carrier.
// RL13: receive starts enabled in mode zero; counting begins at first event.
// RL14: edge select field chooses which receive edges qualify.
// RL15: receive counter counts carrier periods, or infrared clocks when selected.
// RL16: later events store pin level, capture counter, clear it if reload set.
// RL17: receive counter wrap before an event sets the overflow flag.
// RL18: receive continues until transmit mode is chosen or enable cleared.
// RL19: burst mode does not capture; modulation time counts qualified edges.
// RL20: burst mode sets interval flag after two carrier periods without edge.
// RL21: burst enable rising loads the modulation time register with one.
// RL22: burst mode keeps counter clock choice and reload-on-edge choice.
// RL23: timer operates only while enable is one.
// RL24: while disabled, transmit pin follows manual output and enable bits.
// RL25: interrupt only when interrupt enable is one.
// RL26: flags stay set until software clears them.
module ir_carrier_modulation_timer
  import ir_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ir_timer_pkg::ADDR_W-1:0] addr,
  input wire logic [ir_timer_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ir_timer_pkg::DATA_W-1:0] rdata,
  input wire logic receive_pin,
  output logic transmit_pin,
  output logic transmit_pin_oe,
  output logic envelope_output_pin,
  output logic irq
);
  import ir_timer_pkg::*;

  logic [15:0] control;
  logic [15:0] carrier_register;
  logic [15:0] modulation_time_register;
  logic [15:0] interval_counter;
  logic [1:0] power_control_register;
  logic interval_flag;
  logic overflow_flag;
  state_t state;
  state_t next_state;
  logic infrared_input_clock;
  logic rx_s1, rx_s2, rx_s3;
  logic [15:0] carr_l;
  logic pol_l;
  logic data_l;
  logic carr_high;
  logic [7:0] carr_cnt;
  logic [1:0] gap_cnt;

  logic ir_enable, mode_select, tx_polarity, tx_data_bit;
  logic carrier_count_select, rx_reload, burst_count_enable, ir_interrupt_enable;
  logic [1:0] envelope_select;
  logic [1:0] rx_edge_select;
  logic [2:0] clock_divider_field;
  logic manual_pin_output, manual_pin_enable;

  assign ir_enable = control[B_ENABLE];
  assign mode_select = control[B_MODE];
  assign tx_polarity = control[B_POL];
  assign tx_data_bit = control[B_DATA];
  assign carrier_count_select = control[B_CCS];
  assign rx_reload = control[B_RELOAD];
  assign burst_count_enable = control[B_BURST];
  assign ir_interrupt_enable = control[B_IE];
  assign envelope_select = control[B_ENV +: 2];
  assign rx_edge_select = control[B_EDGE +: 2];
  assign clock_divider_field = control[B_DIV +: 3];
  assign manual_pin_output = power_control_register[B_MAN_OUT];
  assign manual_pin_enable = power_control_register[B_MAN_EN];

  ir_clock_divider u_div (
    .clk(clk),
    .rstn(rstn),
    .div(clock_divider_field),
    .tick(infrared_input_clock)
  );

  // receive pin synchroniser and edge qualification
  logic rise, fall, qual;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // receiver idles high, so no false edge follows reset
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end
    else
    begin
      rx_s1 <= receive_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  assign rise = rx_s2 && !rx_s3;
  assign fall = !rx_s2 && rx_s3;
  assign qual = (rx_edge_select == EDGE_FALL) ? fall : // RL14
                (rx_edge_select == EDGE_RISE) ? rise : (rise || fall);

  // operating state
  logic tx_start, rx_start, in_rx, rx_run;
  always_comb
  begin
    next_state = ST_OFF; // RL23
    if (ir_enable)
    begin
      if (mode_select)
        next_state = ST_TX; // RL18
      else
        case (state)
          ST_RX_RUN: next_state = ST_RX_RUN;
          ST_RX_WAIT: next_state = qual ? ST_RX_RUN : ST_RX_WAIT; // RL13
          default: next_state = ST_RX_WAIT; // RL9
        endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  assign tx_start = ir_enable && mode_select && (state != ST_TX); // RL7
  assign in_rx = (state == ST_RX_WAIT) || (state == ST_RX_RUN);
  assign rx_start = ir_enable && !mode_select && !in_rx;
  assign rx_run = (state == ST_RX_RUN);

  // carrier generator
  logic [15:0] carr_src;
  logic carrier_tick, cnt_tick, tx_reload;
  assign carr_src = (state == ST_TX) ? carr_l : carrier_register;
  assign carrier_tick = infrared_input_clock && (carr_cnt == 8'h00) && !carr_high;
  assign cnt_tick = carrier_count_select ? infrared_input_clock : carrier_tick; // RL5 RL15 RL22
  assign tx_reload = (state == ST_TX) && cnt_tick && (interval_counter == COUNT_ZERO);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      carr_high <= 1'b1;
      carr_cnt <= 8'h00;
    end
    else if (!ir_enable || tx_start || tx_reload || rx_start)
    begin
      carr_high <= 1'b1;
      carr_cnt <= carrier_register[15:8]; // RL3
    end
    else if (infrared_input_clock)
    begin
      if (carr_cnt == 8'h00)
      begin
        carr_high <= !carr_high; // RL2
        carr_cnt <= carr_high ? carr_src[7:0] : carr_src[15:8];
      end
      else
        carr_cnt <= carr_cnt - 8'h01;
    end
  end

  // interval settings latched at the start of each transmit interval
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      carr_l <= CARRIER_RST;
      pol_l <= 1'b0;
      data_l <= 1'b0;
    end
    else if (tx_start || tx_reload)
    begin
      carr_l <= carrier_register; // RL3 RL8
      pol_l <= tx_polarity;
      data_l <= tx_data_bit;
    end
  end

  // interval counter
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      interval_counter <= COUNT_ZERO;
    else if (tx_start)
      interval_counter <= modulation_time_register;
    else if ((state == ST_TX) && cnt_tick)
      interval_counter <= tx_reload ? modulation_time_register : // RL8 RL10
                          interval_counter - 16'h0001;
    else if (rx_start || ((state == ST_RX_WAIT) && qual))
      interval_counter <= COUNT_ZERO; // RL13
    else if (rx_run)
    begin
      if (qual && rx_reload)
        interval_counter <= COUNT_ZERO; // RL16 RL22
      else if (cnt_tick)
        interval_counter <= interval_counter + 16'h0001;
    end
  end

  // burst gap detection
  logic gap_set;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      gap_cnt <= 2'h0;
    else if (rx_start || qual)
      gap_cnt <= 2'h0;
    else if (rx_run && carrier_tick && (gap_cnt != GAP_PERIODS))
      gap_cnt <= gap_cnt + 2'h1;
  end
  assign gap_set = burst_count_enable && rx_run && carrier_tick && !qual &&
                   (gap_cnt == GAP_PERIODS - 2'h1); // RL20

  // register writes
  logic wr_ctrl, capture, burst_rise, iflag_set, oflag_set;
  assign wr_ctrl = wr && (addr == OFF_CONTROL);
  assign capture = rx_run && qual && !burst_count_enable; // RL19
  assign burst_rise = wr_ctrl && wdata[B_BURST] && !burst_count_enable;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      control <= CONTROL_RST;
    else
    begin
      if (wr_ctrl)
        control <= wdata & CONTROL_MASK;
      if (capture)
        control[B_DATA] <= rx_s2; // RL16
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      modulation_time_register <= MOD_TIME_RST;
    else if (capture)
      modulation_time_register <= interval_counter; // RL16
    else if (burst_count_enable && in_rx && qual)
      modulation_time_register <= modulation_time_register + 16'h0001; // RL19
    else if (burst_rise)
      modulation_time_register <= BURST_START; // RL21
    else if (wr && (addr == OFF_MOD_TIME))
      modulation_time_register <= wdata;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      carrier_register <= CARRIER_RST;
      power_control_register <= POWER_RST;
    end
    else
    begin
      if (wr && (addr == OFF_CARRIER))
        carrier_register <= wdata;
      if (wr && (addr == OFF_POWER))
        power_control_register <= wdata[1:0];
    end
  end

  // sticky flags, a set in the clearing cycle wins
  logic wr_stat;
  assign wr_stat = wr && (addr == OFF_STATUS);
  assign iflag_set = tx_reload || capture || gap_set;
  assign oflag_set = rx_run && !tx_start && cnt_tick && (interval_counter == COUNT_MAX) &&
                     !(qual && rx_reload);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      interval_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end
    else
    begin
      interval_flag <= iflag_set || (interval_flag && !(wr_stat && wdata[B_IFLAG])); // RL8 RL26
      overflow_flag <= oflag_set || (overflow_flag && !(wr_stat && wdata[B_OFLAG])); // RL17 RL26
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= (interval_flag || overflow_flag) && ir_interrupt_enable; // RL25
  end

  // pin drive
  logic wave;
  assign wave = carr_high ^ pol_l; // RL4
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      transmit_pin <= 1'b0;
      transmit_pin_oe <= 1'b0;
      envelope_output_pin <= 1'b0;
    end
    else if (!ir_enable)
    begin
      transmit_pin <= manual_pin_output; // RL24
      transmit_pin_oe <= manual_pin_enable;
      envelope_output_pin <= 1'b0;
    end
    else
    begin
      transmit_pin_oe <= 1'b1;
      if (state != ST_TX)
        transmit_pin <= tx_polarity; // RL4 RL9
      else if (envelope_select == ENV_CONTINUOUS)
        transmit_pin <= wave; // RL12
      else
        transmit_pin <= data_l ? wave : pol_l; // RL6 RL12
      envelope_output_pin <= (state == ST_TX) &&
                             ((envelope_select == ENV_MODULATED) ||
                              (envelope_select == ENV_CONTINUOUS)) &&
                             (data_l ^ pol_l); // RL11
    end
  end

  // read port
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 16'h0000;
    else if (rd)
      case (addr)
        OFF_CONTROL: rdata <= control;
        OFF_STATUS: rdata <= {14'h0000, overflow_flag, interval_flag};
        OFF_CARRIER: rdata <= carrier_register;
        OFF_MOD_TIME: rdata <= modulation_time_register;
        OFF_COUNT: rdata <= interval_counter;
        OFF_POWER: rdata <= {14'h0000, power_control_register};
        default: rdata <= 16'h0000;
      endcase
    else
      rdata <= 16'h0000;
  end

  property p_manual;
    @(posedge clk) disable iff (!rstn)
      !ir_enable |=> (transmit_pin_oe == $past(manual_pin_enable)) &&
                     (transmit_pin == $past(manual_pin_output));
  endproperty
  a_manual: assert property (p_manual) // RL24
    else $error("disabled pin not following manual bits");

  property p_reload;
    @(posedge clk) disable iff (!rstn)
      tx_reload |=> (interval_counter == $past(modulation_time_register)) && interval_flag;
  endproperty
  a_reload: assert property (p_reload) // RL8
    else $error("interval end did not reload and flag");

  property p_count_down;
    @(posedge clk) disable iff (!rstn)
      (state == ST_TX) && cnt_tick && !tx_reload && ir_enable && mode_select
        |=> interval_counter == $past(interval_counter) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down) // RL10
    else $error("transmit counter did not step down");

  property p_capture;
    @(posedge clk) disable iff (!rstn)
      capture |=> (modulation_time_register == $past(interval_counter)) &&
                  (tx_data_bit == $past(rx_s2));
  endproperty
  a_capture: assert property (p_capture) // RL16
    else $error("receive capture lost");

  property p_overflow;
    @(posedge clk) disable iff (!rstn)
      oflag_set |=> overflow_flag && (interval_counter == COUNT_ZERO);
  endproperty
  a_overflow: assert property (p_overflow) // RL17
    else $error("receive wrap not flagged");

  property p_burst_load;
    @(posedge clk) disable iff (!rstn)
      burst_rise && !(in_rx && qual) |=> modulation_time_register == BURST_START;
  endproperty
  a_burst_load: assert property (p_burst_load) // RL21
    else $error("burst start did not load one");

  property p_irq;
    @(posedge clk) disable iff (!rstn)
      irq |-> $past(ir_interrupt_enable) && $past(interval_flag || overflow_flag);
  endproperty
  a_irq: assert property (p_irq) // RL25
    else $error("interrupt without enable or flag");

  property p_carrier_switch;
    @(posedge clk) disable iff (!rstn)
      ir_enable && infrared_input_clock && (carr_cnt == 8'h00) &&
      !tx_start && !tx_reload && !rx_start
        |=> carr_high != $past(carr_high);
  endproperty
  a_carrier_switch: assert property (p_carrier_switch) // RL2
    else $error("carrier phase did not switch");

  property p_flag_hold;
    @(posedge clk) disable iff (!rstn)
      interval_flag && !(wr_stat && wdata[B_IFLAG]) |=> interval_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RL26
    else $error("interval flag dropped without clear");
endmodule

// File: ir_clock_divider.sv
// Purpose: infrared input clock tick, system clock divided by a power of two
// Assumes: tick is a one-cycle pulse on the system clock
// Notes: divider value may change at any time; the next tick follows the new ratio
`timescale 1ns/1ps
module ir_clock_divider
  import ir_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] div,
  output logic tick
);
  logic [DIV_CNT_W-1:0] cnt;
  logic [DIV_CNT_W-1:0] mask;

  assign mask = DIV_CNT_W'((8'h01 << div) - 8'h01);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= cnt + DIV_CNT_W'(1);
      tick <= ((cnt & mask) == mask); // RL1
    end
  end

  property p_div_zero;
    @(posedge clk) disable iff (!rstn)
      (div == 3'h0) |=> tick;
  endproperty
  a_div_zero: assert property (p_div_zero) // RL1
    else $error("undivided infrared clock missed a tick");
endmodule

// File: ir_far_side.sv
// Purpose: infrared receiver and LED stand-in at the far side of the timer pins
// Assumes: receiver output idles high, changes just after a rising clock edge
// Notes: measure reports one high and one low phase of the light seen on the LED
`timescale 1ns/1ps
module ir_far_side
(
  input wire logic clk,
  input wire logic transmit_pin,
  input wire logic transmit_pin_oe,
  output logic receive_pin
);
  initial receive_pin = 1'b1;

  // edges closer than one cycle would be lost in the pin synchroniser
  task automatic send(input logic lvl, input int gap);
    @(posedge clk);
    receive_pin <= lvl;
    repeat (gap - 1) @(posedge clk);
  endtask

  // bounded, so a silent LED comes back as zero lengths
  task automatic measure(output int hi, output int lo);
    int n;
    hi = 0;
    lo = 0;
    n = 0;
    @(posedge clk);
    while (transmit_pin !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    while (transmit_pin !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    // skip the first phase, the divider phase may cut it short
    while (transmit_pin !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    while (transmit_pin !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    while (transmit_pin === 1'b1 && transmit_pin_oe === 1'b1 && n < 4000)
    begin
      @(posedge clk);
      hi++;
      n++;
    end
    while (transmit_pin === 1'b0 && n < 4000)
    begin
      @(posedge clk);
      lo++;
      n++;
    end
  endtask
endmodule

// File: ir_timer_pkg.sv
// Purpose: shared constants and types of the infrared carrier and modulation timer
// Assumes: 16-bit register port, word addressed, 100 MHz system clock
// Notes: offsets are word indices on the plain register port
package ir_timer_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [2:0] OFF_CONTROL = 3'h0;
  localparam logic [2:0] OFF_STATUS = 3'h1;
  localparam logic [2:0] OFF_CARRIER = 3'h2;
  localparam logic [2:0] OFF_MOD_TIME = 3'h3;
  localparam logic [2:0] OFF_COUNT = 3'h4;
  localparam logic [2:0] OFF_POWER = 3'h5;
  // control field positions
  localparam int B_ENABLE = 0;
  localparam int B_MODE = 1;
  localparam int B_POL = 2;
  localparam int B_DATA = 3;
  localparam int B_CCS = 4;
  localparam int B_RELOAD = 5;
  localparam int B_BURST = 6;
  localparam int B_IE = 7;
  localparam int B_ENV = 8;
  localparam int B_EDGE = 10;
  localparam int B_DIV = 12;
  // status and power field positions
  localparam int B_IFLAG = 0;
  localparam int B_OFLAG = 1;
  localparam int B_MAN_OUT = 0;
  localparam int B_MAN_EN = 1;
  // writable bits and reset values
  localparam logic [15:0] CONTROL_MASK = 16'h7FFF;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] CARRIER_RST = 16'h0000;
  localparam logic [15:0] MOD_TIME_RST = 16'h0000;
  localparam logic [1:0] POWER_RST = 2'h0;
  // counter constants
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] BURST_START = 16'h0001;
  localparam logic [1:0] GAP_PERIODS = 2'h2;
  localparam int DIV_CNT_W = 7;
  // envelope and edge encodings
  localparam logic [1:0] ENV_MODULATED = 2'b01;
  localparam logic [1:0] ENV_CONTINUOUS = 2'b10;
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RX_WAIT = 2'b01,
    ST_RX_RUN = 2'b11,
    ST_TX = 2'b10
  } state_t;
endpackage

// File: tb.sv
// Purpose: self-checking bench for the infrared carrier and modulation timer
// Assumes: 100 MHz clock, registers reached over the plain strobed port
// Notes: each scenario is a task that drives the block and judges the answer
`timescale 1ns/1ps
module tb;
  import ir_timer_pkg::*;
  localparam logic [15:0] C_EN = 16'h0001 << B_ENABLE;
  localparam logic [15:0] C_TX = 16'h0001 << B_MODE;
  localparam logic [15:0] C_POL = 16'h0001 << B_POL;
  localparam logic [15:0] C_DATA = 16'h0001 << B_DATA;
  localparam logic [15:0] C_CCS = 16'h0001 << B_CCS;
  localparam logic [15:0] C_RLD = 16'h0001 << B_RELOAD;
  localparam logic [15:0] C_BURST = 16'h0001 << B_BURST;
  localparam logic [15:0] C_IE = 16'h0001 << B_IE;
  logic clk, rstn, wr, rd, receive_pin, transmit_pin, transmit_pin_oe;
  logic envelope_output_pin, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  int bad_count, comparisons;

  ir_carrier_modulation_timer dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .receive_pin(receive_pin),
    .transmit_pin(transmit_pin), .transmit_pin_oe(transmit_pin_oe),
    .envelope_output_pin(envelope_output_pin), .irq(irq));
  ir_far_side far (.clk(clk), .transmit_pin(transmit_pin),
    .transmit_pin_oe(transmit_pin_oe), .receive_pin(receive_pin));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 200)
    begin
      settle(1);
      n++;
    end
    chk1(irq, lvl);
  endtask

  task automatic t_reset;
    logic [15:0] v;
    wr_reg(OFF_COUNT, 16'h1234);
    wr_reg(3'h6, 16'hFFFF);
    for (int a = 0; a < 8; a++)
    begin
      rd_reg(3'(a), v);
      chk16(v, 16'h0000);
    end
  endtask

  task automatic t_manual_idle;
    wr_reg(OFF_POWER, 16'h0003);
    settle(3);
    chk1(transmit_pin, 1'b1);
    chk1(transmit_pin_oe, 1'b1);
    wr_reg(OFF_POWER, 16'h0001);
    settle(3);
    chk1(transmit_pin_oe, 1'b0);
    wr_reg(OFF_CONTROL, C_EN | C_POL);
    settle(3);
    chk1(transmit_pin, 1'b1);
    wr_reg(OFF_CONTROL, C_EN);
    settle(3);
    chk1(transmit_pin, 1'b0);
    chk1(transmit_pin_oe, 1'b1);
  endtask

  task automatic t_carrier;
    int dv[4] = '{0, 1, 2, 0};
    int hx[4] = '{3, 6, 12, 2};
    int lx[4] = '{2, 4, 8, 3};
    int hi, lo;
    wr_reg(OFF_CARRIER, 16'h0201);
    wr_reg(OFF_MOD_TIME, 16'h0040);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(OFF_CONTROL, 16'h0000);
      wr_reg(OFF_CONTROL, C_EN | C_TX | C_DATA | (i == 3 ? C_POL : 16'h0000)
        | (16'(dv[i]) << B_DIV));
      far.measure(hi, lo);
      chk16(16'(hi), 16'(hx[i]));
      chk16(16'(lo), 16'(lx[i]));
    end
  endtask

  task automatic t_interval;
    longint t0;
    logic [15:0] v;
    wr_reg(OFF_CONTROL, 16'h0000);
    wr_reg(OFF_MOD_TIME, 16'h0009);
    wr_reg(OFF_CONTROL, C_EN | C_TX | C_DATA | C_CCS | C_IE);
    wr_reg(OFF_STATUS, 16'h0003);
    wait_irq(1'b0);
    wait_irq(1'b1);
    t0 = $time;
    wr_reg(OFF_STATUS, 16'h0001);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk16(16'(($time - t0) / 10), 16'h000A);
    wr_reg(OFF_CONTROL, C_EN | C_TX | C_DATA | C_CCS);
    settle(12);
    rd_reg(OFF_STATUS, v);
    chk1(v[B_IFLAG], 1'b1);
    chk1(irq, 1'b0);
    wr_reg(OFF_CONTROL, 16'h0000);
    settle(3);
    chk1(transmit_pin, 1'b1);
    chk1(transmit_pin_oe, 1'b0);
  endtask

  task automatic t_envelope;
    int hi, lo;
    wr_reg(OFF_MOD_TIME, 16'h0003);
    wr_reg(OFF_CONTROL, C_EN | C_TX | C_DATA | C_CCS | (16'h0001 << B_ENV));
    settle(12);
    chk1(envelope_output_pin, 1'b1);
    wr_reg(OFF_CONTROL, C_EN | C_TX | C_DATA | C_CCS | C_POL | (16'h0001 << B_ENV));
    settle(12);
    chk1(envelope_output_pin, 1'b0);
    wr_reg(OFF_CONTROL, 16'h0000);
    wr_reg(OFF_CONTROL, C_EN | C_TX | (16'h0002 << B_ENV));
    far.measure(hi, lo);
    chk16(16'(hi), 16'h0003);
    chk16(16'(lo), 16'h0002);
    chk1(envelope_output_pin, 1'b0);
  endtask

  task automatic t_receive;
    logic [1:0] es[3] = '{EDGE_FALL, EDGE_RISE, 2'b10};
    logic ed[3] = '{1'b0, 1'b1, 1'b1};
    int sp[3] = '{20, 20, 10};
    logic [15:0] v;
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(OFF_CONTROL, 16'h0000);
      wr_reg(OFF_STATUS, 16'h0003);
      wr_reg(OFF_CONTROL, C_EN | C_CCS | C_RLD | (16'(es[i]) << B_EDGE));
      far.send(1'b0, 10);
      far.send(1'b1, 10);
      far.send(1'b0, 10);
      far.send(1'b1, 10);
      settle(6);
      rd_reg(OFF_MOD_TIME, v);
      chk1(v === 16'(sp[i]) || v === 16'(sp[i] - 1), 1'b1);
      rd_reg(OFF_CONTROL, v);
      chk1(v[B_DATA], ed[i]);
      rd_reg(OFF_STATUS, v);
      chk1(v[B_IFLAG], 1'b1);
    end
  endtask

  task automatic t_overflow;
    logic [15:0] v;
    wr_reg(OFF_CONTROL, 16'h0000);
    wr_reg(OFF_STATUS, 16'h0003);
    wr_reg(OFF_CONTROL, C_EN | C_CCS | (16'(EDGE_RISE) << B_EDGE));
    far.send(1'b0, 4);
    far.send(1'b1, 4);
    settle(65545);
    rd_reg(OFF_STATUS, v);
    chk16(v, 16'h0002);
    chk1(irq, 1'b0);
  endtask

  task automatic t_burst;
    logic [15:0] v;
    wr_reg(OFF_CONTROL, 16'h0000);
    wr_reg(OFF_CARRIER, 16'h0101);
    wr_reg(OFF_CONTROL, C_EN | C_BURST | (16'h0002 << B_EDGE));
    rd_reg(OFF_MOD_TIME, v);
    chk16(v, BURST_START);
    far.send(1'b0, 3);
    far.send(1'b1, 3);
    far.send(1'b0, 3);
    settle(2);
    rd_reg(OFF_MOD_TIME, v);
    chk16(v, 16'h0004);
    wr_reg(OFF_STATUS, 16'h0003);
    settle(20);
    rd_reg(OFF_STATUS, v);
    chk1(v[B_IFLAG], 1'b1);
  endtask

  task automatic test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_manual_idle();
    t_carrier();
    t_interval();
    t_envelope();
    t_receive();
    t_overflow();
    t_burst();
    test_done();
  end

  initial
  begin
    #1000000;
    bad_count++;
    test_done();
  end
endmodule
